// ==== pis_pkg.sv ====
// Shared constants, types and helpers for the two-wire slave port and its master
package pis_pkg;

    // Byte framing on the wire
    localparam logic [3:0] LAST_BIT   = 4'h7;    // Bit count of the eighth data bit
    localparam logic [3:0] ACK_SLOT   = 4'h8;    // Bit count of the acknowledge slot
    localparam logic       ACK_LVL    = 1'b0;    // Line level that acknowledges
    localparam logic       RW_READ    = 1'b1;    // Direction bit value for a read
    localparam logic [6:0] SLAVE_ADDR = 7'h7E;   // Fixed slave address
    localparam logic [7:0] PTR_RESET  = 8'h00;   // Register pointer after reset
    localparam logic [7:0] ONE_BYTE   = 8'h01;   // Count of a final byte

    // Timing of the serial clock made by the master
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    // Slave transfer phase
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_REG, PH_WDATA, PH_RDATA} pis_phase_t;
    // Master line sequencer and byte step
    typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} pis_mst_t;
    typedef enum logic [2:0] {S_DEVW, S_REG, S_WR, S_DEVR, S_RD} pis_step_t;

    // Glitch filter: a new level counts once second and third stage agree
    function automatic logic pis_filt(input logic s2, input logic s3, input logic cur);
        return (s2 == s3) ? s2 : cur;
    endfunction : pis_filt

endpackage : pis_pkg

// ==== pis_bus_if.sv ====
// Two-wire bus between master and slave with open-drain resolution
`timescale 1ns/10ps
interface pis_bus_if;
    logic scl_o;
    logic scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // Pull-up wins unless some party pulls low
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

    modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
    modport mst (input scl, input sda, output scl_o, output scl_oe,
                 output m_sda_o, output m_sda_oe);
endinterface : pis_bus_if

// ==== pis_slave.sv ====
// Slave end of the two-wire register port
`timescale 1ns/10ps
// What this block and its master do
// - Sample data once per clock-high pulse
// - Data change at clock high abandons transfer
// - Data changes only while clock low
// - Bytes are eight bits, MSB first, then ack
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Bus busy from start until after stop
// - Repeated start restarts address reception
// - Master gives ninth clock for acknowledge
// - Sender releases data during acknowledge clock
// - Receiver holds data low through ack high
// - Master leaves ack high on last read
// - Acknowledge only the fixed seven-bit address
// - Seven address bits, eighth bit is direction
// - Register address byte, then stored data byte
// - Write pointer increments after each data ack
// - Master ends writes with a stop
// - Read via repeated start, direction one
// - Master ack advances pointer, next byte sent
// - Master ends reads with nack, stop
module pis_slave
    import pis_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Two-wire bus
    pis_bus_if.dev          bus,
    // Register file side
    output logic [7:0]      reg_addr,
    output logic            wr_stb,
    output logic [7:0]      wr_data,
    output logic            rd_stb,
    input  wire logic [7:0] rd_data,
    // Status
    output logic            busy
);

    logic [2:0]  scl_sy_ff, nxt_scl_sy;
    logic [2:0]  sda_sy_ff, nxt_sda_sy;
    logic        scl_f_ff, nxt_scl_f;
    logic        sda_f_ff, nxt_sda_f;
    logic        scl_p_ff, nxt_scl_p;
    logic        sda_p_ff, nxt_sda_p;
    pis_phase_t  phase_ff, nxt_phase;
    logic [3:0]  bitcnt_ff, nxt_bitcnt;
    logic [6:0]  shreg_ff, nxt_shreg;
    logic [7:0]  tx_ff, nxt_tx;
    logic        ack_ff, nxt_ack;
    logic        rw_ff, nxt_rw;
    logic [7:0]  ptr_ff, nxt_ptr;
    logic        oe_ff, nxt_oe;
    logic        busy_ff, nxt_busy;
    logic        wr_stb_ff, nxt_wr_stb;
    logic [7:0]  wr_data_ff, nxt_wr_data;
    logic        rd_stb_ff, nxt_rd_stb;
    logic        sda_o_ff;
    logic        scl_rise, scl_fall, start_c, stop_c;
    logic [7:0]  rx_byte;

    // Line events on filtered levels
    assign scl_rise = scl_f_ff && !scl_p_ff;
    assign scl_fall = !scl_f_ff && scl_p_ff;
    assign start_c  = scl_f_ff && scl_p_ff && sda_p_ff && !sda_f_ff;
    assign stop_c   = scl_f_ff && scl_p_ff && !sda_p_ff && sda_f_ff;
    assign rx_byte  = {shreg_ff, sda_f_ff};

    // Next state of synchronisers and protocol engine
    always_comb begin
        nxt_scl_sy  = {scl_sy_ff[1:0], bus.scl};
        nxt_sda_sy  = {sda_sy_ff[1:0], bus.sda};
        nxt_scl_f   = pis_filt(scl_sy_ff[1], scl_sy_ff[2], scl_f_ff);
        nxt_sda_f   = pis_filt(sda_sy_ff[1], sda_sy_ff[2], sda_f_ff);
        nxt_scl_p   = scl_f_ff;
        nxt_sda_p   = sda_f_ff;
        nxt_phase   = phase_ff;
        nxt_bitcnt  = bitcnt_ff;
        nxt_shreg   = shreg_ff;
        nxt_tx      = tx_ff;
        nxt_ack     = ack_ff;
        nxt_rw      = rw_ff;
        nxt_ptr     = ptr_ff;
        nxt_oe      = oe_ff;
        nxt_busy    = busy_ff;
        nxt_wr_stb  = 1'b0;
        nxt_wr_data = wr_data_ff;
        nxt_rd_stb  = 1'b0;
        if (start_c) begin
            // Fresh or repeated start drops any byte in flight
            nxt_phase  = PH_ADDR;
            nxt_bitcnt = '0;
            nxt_oe     = 1'b0;
            nxt_busy   = 1'b1;
        end else if (stop_c) begin
            nxt_phase = PH_IDLE;
            nxt_oe    = 1'b0;
            nxt_busy  = 1'b0;
        end else if (phase_ff != PH_IDLE && scl_rise) begin
            if (bitcnt_ff == ACK_SLOT) begin
                // End of acknowledge slot
                nxt_bitcnt = '0;
                unique case (phase_ff)
                    PH_ADDR: begin
                        if (!ack_ff) begin
                            nxt_phase = PH_IDLE;
                        end else if (rw_ff == RW_READ) begin
                            nxt_phase = PH_RDATA;
                        end else begin
                            nxt_phase = PH_REG;
                        end
                    end
                    PH_REG: begin
                        nxt_phase = PH_WDATA;
                    end
                    PH_WDATA: begin
                        nxt_ptr = ptr_ff + 8'h01;
                    end
                    PH_RDATA: begin
                        if (sda_f_ff == ACK_LVL) begin
                            nxt_ptr = ptr_ff + 8'h01;
                        end else begin
                            nxt_phase = PH_IDLE;
                        end
                    end
                    default: begin
                        nxt_phase = PH_IDLE;
                    end
                endcase
            end else begin
                // One data bit per high pulse, MSB first
                nxt_shreg  = {shreg_ff[5:0], sda_f_ff};
                nxt_bitcnt = bitcnt_ff + 4'h1;
                if (bitcnt_ff == LAST_BIT) begin
                    unique case (phase_ff)
                        PH_ADDR: begin
                            nxt_ack = (rx_byte[7:1] == SLAVE_ADDR);
                            nxt_rw  = rx_byte[0];
                        end
                        PH_REG: begin
                            nxt_ptr = rx_byte;
                            nxt_ack = 1'b1;
                        end
                        PH_WDATA: begin
                            nxt_wr_stb  = 1'b1;
                            nxt_wr_data = rx_byte;
                            nxt_ack     = 1'b1;
                        end
                        PH_RDATA: begin
                            nxt_ack = 1'b0;
                        end
                        default: begin
                            nxt_ack = 1'b0;
                        end
                    endcase
                end
            end
        end else if (phase_ff != PH_IDLE && scl_fall) begin
            // All line changes happen just after the clock falls
            if (bitcnt_ff == ACK_SLOT) begin
                nxt_oe = (phase_ff != PH_RDATA) && ack_ff;
            end else if (phase_ff == PH_RDATA) begin
                if (bitcnt_ff == '0) begin
                    nxt_tx     = {rd_data[6:0], 1'b0};
                    nxt_oe     = !rd_data[7];
                    nxt_rd_stb = 1'b1;
                end else begin
                    nxt_tx = {tx_ff[6:0], 1'b0};
                    nxt_oe = !tx_ff[7];
                end
            end else begin
                nxt_oe = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sy_ff  <= 3'h7;
            sda_sy_ff  <= 3'h7;
            scl_f_ff   <= 1'b1;
            sda_f_ff   <= 1'b1;
            scl_p_ff   <= 1'b1;
            sda_p_ff   <= 1'b1;
            phase_ff   <= PH_IDLE;
            bitcnt_ff  <= '0;
            shreg_ff   <= '0;
            tx_ff      <= '0;
            ack_ff     <= 1'b0;
            rw_ff      <= 1'b0;
            ptr_ff     <= PTR_RESET;
            oe_ff      <= 1'b0;
            busy_ff    <= 1'b0;
            wr_stb_ff  <= 1'b0;
            wr_data_ff <= '0;
            rd_stb_ff  <= 1'b0;
            sda_o_ff   <= 1'b0;
        end else if (ce) begin
            scl_sy_ff  <= nxt_scl_sy;
            sda_sy_ff  <= nxt_sda_sy;
            scl_f_ff   <= nxt_scl_f;
            sda_f_ff   <= nxt_sda_f;
            scl_p_ff   <= nxt_scl_p;
            sda_p_ff   <= nxt_sda_p;
            phase_ff   <= nxt_phase;
            bitcnt_ff  <= nxt_bitcnt;
            shreg_ff   <= nxt_shreg;
            tx_ff      <= nxt_tx;
            ack_ff     <= nxt_ack;
            rw_ff      <= nxt_rw;
            ptr_ff     <= nxt_ptr;
            oe_ff      <= nxt_oe;
            busy_ff    <= nxt_busy;
            wr_stb_ff  <= nxt_wr_stb;
            wr_data_ff <= nxt_wr_data;
            rd_stb_ff  <= nxt_rd_stb;
            sda_o_ff   <= 1'b0;
        end
    end

    // Outputs straight from registers
    assign bus.s_sda_o  = sda_o_ff;
    assign bus.s_sda_oe = oe_ff;
    assign reg_addr     = ptr_ff;
    assign wr_stb       = wr_stb_ff;
    assign wr_data      = wr_data_ff;
    assign rd_stb       = rd_stb_ff;
    assign busy         = busy_ff;

endmodule : pis_slave

// ==== pis_master.sv ====
// Master end of the two-wire register port
`timescale 1ns/10ps
module pis_master
    import pis_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Two-wire bus
    pis_bus_if.mst          bus,
    // Command
    input  wire logic       go,
    input  wire logic       read,
    input  wire logic [6:0] dev_addr,
    input  wire logic [7:0] reg_ptr,
    input  wire logic [7:0] count,
    input  wire logic [7:0] wr_byte,
    output logic            wr_take,
    output logic [7:0]      rd_byte,
    output logic            rd_valid,
    output logic            done,
    output logic            nack_err,
    output logic            busy
);

    pis_mst_t    st_ff, nxt_st;
    pis_step_t   step_ff, nxt_step;
    logic [1:0]  ph_ff, nxt_ph;
    logic [15:0] q_ff, nxt_q;
    logic [3:0]  bit_ff, nxt_bit;
    logic [7:0]  byte_ff, nxt_byte;
    logic        rd_ff, nxt_rd;
    logic [6:0]  dev_ff, nxt_dev;
    logic [7:0]  reg_ff, nxt_reg;
    logic [7:0]  cnt_ff, nxt_cnt;
    logic        nak_ff, nxt_nak;
    logic        scl_oe_ff, nxt_scl_oe;
    logic        sda_oe_ff, nxt_sda_oe;
    logic [2:0]  sy_ff;
    logic        sda_f_ff;
    logic        take_ff, nxt_take;
    logic [7:0]  rdb_ff, nxt_rdb;
    logic        rdv_ff, nxt_rdv;
    logic        done_ff, nxt_done;
    logic        err_ff, nxt_err;
    logic        busy_ff, nxt_busy;
    logic        tick, tx;

    assign tick = (q_ff == 16'(QTR - 1));
    assign tx   = (step_ff != S_RD);

    // Sequencer: four quarter ticks per serial clock
    always_comb begin
        nxt_st = st_ff;  nxt_step = step_ff;  nxt_ph = ph_ff;  nxt_bit = bit_ff;
        nxt_byte = byte_ff;  nxt_rd = rd_ff;  nxt_dev = dev_ff;  nxt_reg = reg_ff;
        nxt_cnt = cnt_ff;  nxt_nak = nak_ff;  nxt_scl_oe = scl_oe_ff;
        nxt_sda_oe = sda_oe_ff;  nxt_rdb = rdb_ff;  nxt_err = err_ff;  nxt_busy = busy_ff;
        nxt_take = 1'b0;  nxt_rdv = 1'b0;  nxt_done = 1'b0;
        nxt_q = (tick || st_ff == M_IDLE) ? '0 : q_ff + 16'h0001;
        if (st_ff == M_IDLE) begin
            if (go) begin
                nxt_st = M_START;  nxt_step = S_DEVW;  nxt_ph = '0;
                nxt_rd = read;  nxt_dev = dev_addr;  nxt_reg = reg_ptr;
                nxt_cnt = count;  nxt_err = 1'b0;  nxt_busy = 1'b1;
            end
        end else if (tick) begin
            nxt_ph = ph_ff + 2'h1;
            unique case (st_ff)
                M_START: begin
                    // Start, also used as repeated start
                    unique case (ph_ff)
                        2'h0: begin nxt_scl_oe = 1'b1;  nxt_sda_oe = 1'b0; end
                        2'h1: nxt_scl_oe = 1'b0;
                        2'h2: nxt_sda_oe = 1'b1;
                        2'h3: begin
                            nxt_scl_oe = 1'b1;  nxt_st = M_BIT;  nxt_bit = '0;
                            nxt_byte = {dev_ff, step_ff == S_DEVR};
                        end
                    endcase
                end
                M_BIT: begin
                    unique case (ph_ff)
                        2'h0: begin
                            if (bit_ff != ACK_SLOT) nxt_sda_oe = tx && !byte_ff[7];
                            else nxt_sda_oe = !tx && (cnt_ff != ONE_BYTE);
                        end
                        2'h1: nxt_scl_oe = 1'b0;
                        2'h2: begin
                            if (bit_ff != ACK_SLOT) nxt_byte = {byte_ff[6:0], sda_f_ff};
                            else nxt_nak = sda_f_ff;
                        end
                        2'h3: begin
                            nxt_scl_oe = 1'b1;
                            nxt_bit = bit_ff + 4'h1;
                            if (bit_ff == ACK_SLOT) begin
                                nxt_bit = '0;
                                if (tx && nak_ff) begin
                                    nxt_st = M_STOP;  nxt_err = 1'b1;
                                end else begin
                                    unique case (step_ff)
                                        S_DEVW: begin nxt_step = S_REG;  nxt_byte = reg_ff; end
                                        S_REG: begin
                                            if (rd_ff) begin
                                                nxt_step = S_DEVR;  nxt_st = M_START;
                                            end else begin
                                                nxt_step = S_WR;  nxt_byte = wr_byte;
                                                nxt_take = 1'b1;
                                            end
                                        end
                                        S_WR: begin
                                            if (cnt_ff == ONE_BYTE) nxt_st = M_STOP;
                                            else begin
                                                nxt_cnt = cnt_ff - 8'h01;
                                                nxt_byte = wr_byte;  nxt_take = 1'b1;
                                            end
                                        end
                                        S_DEVR: nxt_step = S_RD;
                                        S_RD: begin
                                            nxt_rdb = byte_ff;  nxt_rdv = 1'b1;
                                            if (cnt_ff == ONE_BYTE) nxt_st = M_STOP;
                                            else nxt_cnt = cnt_ff - 8'h01;
                                        end
                                        default: nxt_st = M_STOP;
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    unique case (ph_ff)
                        2'h0: begin nxt_scl_oe = 1'b1;  nxt_sda_oe = 1'b1; end
                        2'h1: nxt_scl_oe = 1'b0;
                        2'h2: nxt_sda_oe = 1'b0;
                        2'h3: begin nxt_st = M_IDLE;  nxt_done = 1'b1;  nxt_busy = 1'b0; end
                    endcase
                end
                default: nxt_st = M_IDLE;
            endcase
        end
    end

    // State registers and data line filter
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= M_IDLE;  step_ff <= S_DEVW;  ph_ff <= '0;  q_ff <= '0;  bit_ff <= '0;
            byte_ff <= '0;  rd_ff <= 1'b0;  dev_ff <= '0;  reg_ff <= '0;  cnt_ff <= '0;
            nak_ff <= 1'b0;  scl_oe_ff <= 1'b0;  sda_oe_ff <= 1'b0;  sy_ff <= 3'h7;
            sda_f_ff <= 1'b1;  take_ff <= 1'b0;  rdb_ff <= '0;  rdv_ff <= 1'b0;
            done_ff <= 1'b0;  err_ff <= 1'b0;  busy_ff <= 1'b0;
        end else if (ce) begin
            st_ff <= nxt_st;  step_ff <= nxt_step;  ph_ff <= nxt_ph;  q_ff <= nxt_q;
            bit_ff <= nxt_bit;  byte_ff <= nxt_byte;  rd_ff <= nxt_rd;  dev_ff <= nxt_dev;
            reg_ff <= nxt_reg;  cnt_ff <= nxt_cnt;  nak_ff <= nxt_nak;
            scl_oe_ff <= nxt_scl_oe;  sda_oe_ff <= nxt_sda_oe;
            sy_ff <= {sy_ff[1:0], bus.sda};
            sda_f_ff <= pis_filt(sy_ff[1], sy_ff[2], sda_f_ff);
            take_ff <= nxt_take;  rdb_ff <= nxt_rdb;  rdv_ff <= nxt_rdv;
            done_ff <= nxt_done;  err_ff <= nxt_err;  busy_ff <= nxt_busy;
        end
    end

    // Open-drain outputs only ever pull low
    assign bus.scl_o    = 1'b0;
    assign bus.m_sda_o  = 1'b0;
    assign bus.scl_oe   = scl_oe_ff;
    assign bus.m_sda_oe = sda_oe_ff;
    assign wr_take      = take_ff;
    assign rd_byte      = rdb_ff;
    assign rd_valid     = rdv_ff;
    assign done         = done_ff;
    assign nack_err     = err_ff;
    assign busy         = busy_ff;

endmodule : pis_master

// ==== pis_slave_assertions.sv ====
// Concurrent checks on the two-wire bus joining master and slave
`timescale 1ns/10ps
module pis_slave_assertions
    import pis_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus signals
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic m_sda_oe
);
    logic       scl_ff, sda_ff, first_ff, rd_ff, ign_ff;
    logic       nxt_first, nxt_rd, nxt_ign;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic       rise, start_w, stop_w;

    // Clock rise, start and stop seen on the wired lines
    assign rise    = scl && !scl_ff;
    assign start_w = scl && scl_ff && sda_ff && !sda;
    assign stop_w  = scl && scl_ff && !sda_ff && sda;

    // Follow bit count, address match and direction of each frame
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_sh    = sh_ff;
        nxt_first = first_ff;
        nxt_rd    = rd_ff;
        nxt_ign   = ign_ff;
        if (start_w || stop_w) begin
            nxt_cnt   = 4'h0;
            nxt_first = start_w;
            nxt_rd    = 1'b0;
            nxt_ign   = stop_w;  // Idle after stop
        end else if (rise) begin
            nxt_sh  = {sh_ff[6:0], sda};
            nxt_cnt = (cnt_ff == ACK_SLOT) ? 4'h0 : cnt_ff + 4'h1;
            if (cnt_ff == ACK_SLOT) begin
                nxt_first = 1'b0;
            end
            if (first_ff && cnt_ff == LAST_BIT) begin
                nxt_ign = (sh_ff[6:0] != SLAVE_ADDR);
                nxt_rd  = (sda == RW_READ);
            end
        end
    end

    // Register the tracking state
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_ff   <= 1'b1;
            sda_ff   <= 1'b1;
            cnt_ff   <= 4'h0;
            sh_ff    <= 8'h00;
            first_ff <= 1'b0;
            rd_ff    <= 1'b0;
            ign_ff   <= 1'b1;
        end else begin
            scl_ff   <= scl;
            sda_ff   <= sda;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
            first_ff <= nxt_first;
            rd_ff    <= nxt_rd;
            ign_ff   <= nxt_ign;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Ninth clock rise of a frame, the acknowledge slot
    sequence nine_rise_s;
        rise && cnt_ff == ACK_SLOT;
    endsequence

    low_only_a: assert property (s_sda_oe |-> !s_sda_o)
        else $error("slave drives data high");
    oe_in_low_a: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("slave data changed while clock high");
    master_edge_a: assert property ($changed(m_sda_oe) && scl |-> start_w || stop_w)
        else $error("master data changed at clock high outside start or stop");
    addr_ack_a: assert property (nine_rise_s ##0 (first_ff && !ign_ff) |-> (!sda)[*5])
        else $error("matching address not acknowledged");
    byte_ack_a: assert property (nine_rise_s ##0 (!first_ff && !ign_ff && !rd_ff) |-> (!sda)[*5])
        else $error("written byte not acknowledged");
    tx_release_a: assert property (nine_rise_s ##0 (rd_ff && !first_ff) |-> !s_sda_oe)
        else $error("slave holds data in read acknowledge slot");
    nack_idle_a: assert property (nine_rise_s ##0 (rd_ff && !first_ff && sda) |=> (!s_sda_oe)[*8])
        else $error("slave drives after negative acknowledge");
    unaddr_quiet_a: assert property (ign_ff |-> !s_sda_oe)
        else $error("slave drives while not addressed");
endmodule : pis_slave_assertions

// ==== pis_slave_bench.sv ====
// Bench joining master and slave ends over one two-wire bus
`timescale 1ns/10ps
module pis_slave_bench;
    import pis_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       go  = 1'b0;
    logic       read = 1'b0;
    logic [6:0] dev_addr = SLAVE_ADDR;
    logic [7:0] reg_ptr = 8'h00;
    logic [7:0] count = 8'h01;
    logic [7:0] wr_byte, rd_byte, reg_addr, wr_data, rd_data;
    logic       wr_take, rd_valid, done, nack_err, wr_stb, s_busy, m_busy, s_rd_stb;
    logic [7:0] regs [256];
    logic [7:0] wsrc [4];
    logic [7:0] rgot [4];
    int         wn = 0, rn = 0, sn = 0, errors = 0, tests_run = 0;

    pis_bus_if pis_bus_if_inst ();
    pis_master #(.QTR(6)) pis_master_inst (.clk(clk), .rst(rst), .ce(1'b1),
        .bus(pis_bus_if_inst), .go(go), .read(read), .dev_addr(dev_addr), .reg_ptr(reg_ptr),
        .count(count), .wr_byte(wr_byte), .wr_take(wr_take), .rd_byte(rd_byte),
        .rd_valid(rd_valid), .done(done), .nack_err(nack_err), .busy(m_busy));
    pis_slave pis_slave_inst (.clk(clk), .rst(rst), .ce(1'b1), .bus(pis_bus_if_inst),
        .reg_addr(reg_addr), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(s_rd_stb),
        .rd_data(rd_data), .busy(s_busy));
    pis_slave_assertions pis_slave_assertions_inst (.clk(clk), .rst(rst),
        .scl(pis_bus_if_inst.scl), .sda(pis_bus_if_inst.sda), .s_sda_o(pis_bus_if_inst.s_sda_o),
        .s_sda_oe(pis_bus_if_inst.s_sda_oe), .m_sda_oe(pis_bus_if_inst.m_sda_oe));

    // Clock, register file and byte sources
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    assign rd_data = regs[reg_addr];
    assign wr_byte = wsrc[wn[1:0]];
    always @(posedge clk) begin
        if (wr_stb) regs[reg_addr] <= wr_data;
        if (wr_take) wn <= wn + 1;
        if (s_rd_stb) sn <= sn + 1;
        if (rd_valid) begin
            rgot[rn[1:0]] <= rd_byte;
            rn <= rn + 1;
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h got %h", what, exp, got);
        end
    endtask : check

    // One whole master command, waited for under a bound
    task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [7:0] n);
        @(negedge clk);
        wn = 0;
        rn = 0;
        sn = 0;
        read = rd;
        dev_addr = dev;
        reg_ptr = ptr;
        count = n;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        check("master busy", 8'h01, {7'h00, m_busy});
        for (int k = 0; k < 4000 && done !== 1'b1; k++) @(negedge clk);
        check("done", 8'h01, {7'h00, done});
        check("master idle", 8'h00, {7'h00, m_busy});
        repeat (10) @(negedge clk);
        check("slave busy", 8'h00, {7'h00, s_busy});
    endtask : xfer

    task automatic write_burst;
        wsrc[0] = 8'h3C;
        wsrc[1] = 8'hC3;
        wsrc[2] = 8'h81;
        xfer(1'b0, SLAVE_ADDR, 8'hFE, 8'h03);
        check("reg FE", 8'h3C, regs[8'hFE]);
        check("reg FF", 8'hC3, regs[8'hFF]);
        check("reg 00", 8'h81, regs[8'h00]);
        check("pointer", 8'h01, reg_addr);
        check("nack", 8'h00, {7'h00, nack_err});
        check("loads", 8'h00, 8'(sn));
    endtask : write_burst

    task automatic read_burst;
        xfer(1'b1, SLAVE_ADDR, 8'hFF, 8'h03);
        check("read 0", 8'hC3, rgot[0]);
        check("read 1", 8'h81, rgot[1]);
        check("read 2", 8'h5B, rgot[2]);
        check("pointer", 8'h01, reg_addr);
        check("loads", 8'h03, 8'(sn));
    endtask : read_burst

    task automatic bad_addr;
        wsrc[0] = 8'hEE;
        xfer(1'b0, 7'h3F, 8'h20, 8'h01);
        check("nack", 8'h01, {7'h00, nack_err});
        check("reg 20", 8'h7A, regs[8'h20]);
        check("pointer", 8'h01, reg_addr);
    endtask : bad_addr

    task automatic single_read;
        xfer(1'b1, SLAVE_ADDR, 8'h20, 8'h01);
        check("read 0", 8'h7A, rgot[0]);
        check("pointer", 8'h20, reg_addr);
        check("nack", 8'h00, {7'h00, nack_err});
        check("loads", 8'h01, 8'(sn));
    endtask : single_read

    task automatic results;
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5A;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        write_burst();
        read_burst();
        bad_addr();
        single_read();
        results();
    end

    // Watchdog
    initial begin
        #300000;
        errors++;
        $display("mismatch watchdog expected finish got timeout");
        results();
    end
endmodule : pis_slave_bench
